// ### logic/periph_clk_pkg.sv
// constants for the peripheral clock output and serial mode control
// assumes a single system clock domain and a byte-wide register port
`default_nettype none
package periph_clk_pkg;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CNT_W        = 6;
  // register offsets
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STAT_OFS     = 8'h01;
  localparam logic [7:0]  CTRL_RESET   = 8'hE0;
  localparam logic [7:0]  CTRL_MASK    = 8'hFE;
  // field positions in serial_ctrl_reg0
  localparam int unsigned MODE_LSB     = 5;
  localparam int unsigned PCK_EN_BIT   = 4;
  localparam int unsigned DIV_HI_BIT   = 3;
  localparam int unsigned DIV_LO_BIT   = 2;
  localparam int unsigned SIF_EN_BIT   = 1;
  // status register positions
  localparam int unsigned ST_ACT_BIT   = 0;
  localparam int unsigned ST_PCK_BIT   = 1;
  localparam int unsigned ST_SPI_BIT   = 2;

  typedef enum logic [2:0] {
    MODE_SPI_M_DIV4  = 3'b000,
    MODE_SPI_M_DIV16 = 3'b001,
    MODE_SPI_M_DIV64 = 3'b010,
    MODE_SPI_M_LIRC  = 3'b011,
    MODE_SPI_M_TMR   = 3'b100,
    MODE_SPI_SLAVE   = 3'b101,
    MODE_I2C_SLAVE   = 3'b110,
    MODE_IO          = 3'b111
  } serial_mode_t;

  typedef enum logic [1:0] {
    PCK_DIV2 = 2'b00,
    PCK_DIV4 = 2'b01,
    PCK_DIV8 = 2'b10,
    PCK_TMR  = 2'b11
  } pck_sel_t;

  // toggle every 2**k cycles gives system clock / 2**(k+1)
  localparam logic [2:0] K_DIV2  = 3'h0;
  localparam logic [2:0] K_DIV4  = 3'h1;
  localparam logic [2:0] K_DIV8  = 3'h2;
  localparam logic [2:0] K_DIV16 = 3'h3;
  localparam logic [2:0] K_DIV64 = 3'h5;
endpackage : periph_clk_pkg
`default_nettype wire

// ### logic/rate_toggle.sv
// one clock level generator: toggles on a tick or follows a sampled source
// assumes tick_i and src_i are synchronous to clock_i
`default_nettype none
module rate_toggle (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic clear_i,
  input  wire logic follow_i,
  input  wire logic src_i,
  input  wire logic tick_i,
  output logic      level_o
);
  logic level_q;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || clear_i) begin
      level_q <= 1'b0;
    end else if (follow_i) begin
      level_q <= src_i;
    end else if (tick_i) begin
      level_q <= ~level_q;
    end
  end

  assign level_o = level_q;
endmodule : rate_toggle
`default_nettype wire

// ### logic/periph_clk_out.sv
// peripheral clock output with shared pin, plus serial mode decode
// assumes a synchronous register port, timer match pulses and sleep level on clock_i
// Behaviour
// R1: the enable bit hands the shared pin to the clock output instead of ordinary i/o.
// R2: writing 1 to the enable bit turns the clock output on and writing 0 turns it off.
// R3: the clock output comes from half the timer-0 match rate or a divided system clock.
// R4: the two-bit prescale field picks the system clock ratio for the clock output.
// R5: while the device sleeps the clock output is disabled.
// R6: mode codes 000, 001, 010 give spi master at system clock over 4, 16 and 64.
// R7: mode 011 gives spi master on the low-speed rc clock, 100 at half the timer-0 match rate.
// R8: mode 101 makes the interface an spi slave whose clock the external master supplies.
// R9: the three-bit mode field sets the interface mode, 110 i2c slave and 111 plain i/o.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`default_nettype none
module periph_clk_out (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        sleep_i,
  input  wire logic        timer0_period_match_i,
  input  wire logic        low_speed_rc_clock_i,
  input  wire logic        gpio_out_i,
  input  wire logic        gpio_oe_i,
  output logic             gpio_in_o,
  input  wire logic        periph_clk_out_pin_i,
  output logic             periph_clk_out_pin_o,
  output logic             periph_clk_out_pin_oe_o,
  output logic             serial_if_enable_o,
  output logic      [2:0]  serial_mode_sel_o,
  output logic             spi_master_o,
  output logic             spi_slave_o,
  output logic             i2c_slave_o,
  output logic             io_mode_o,
  output logic             spi_master_clk_o
);
  logic [7:0]                           ctrl_q;
  logic [7:0]                           rdata_q;
  logic [periph_clk_pkg::CNT_W-1:0]     cnt_q;
  logic                                 pin_q;
  logic                                 pin_oe_q;
  logic                                 gpio_in_q;
  logic                                 periph_clk_enable;
  logic [1:0]                           div_sel;
  logic [2:0]                           mode;
  logic                                 pck_act;
  logic                                 pck_tick;
  logic                                 pck_lvl;
  logic                                 spi_act;
  logic                                 spi_tick;
  logic                                 spi_follow;
  logic                                 spi_lvl;
  logic [7:0]                           status;

  // true once every 2**k cycles of the free-running prescaler
  function automatic logic tick_at(input logic [5:0] cnt, input logic [2:0] k);
    logic [6:0] m;
    m = (7'h01 << k) - 7'h01;
    return &(cnt | ~m[5:0]);
  endfunction : tick_at

  assign periph_clk_enable = ctrl_q[periph_clk_pkg::PCK_EN_BIT];
  assign div_sel           = {ctrl_q[periph_clk_pkg::DIV_HI_BIT], ctrl_q[periph_clk_pkg::DIV_LO_BIT]};
  assign mode              = ctrl_q[periph_clk_pkg::MODE_LSB +: 3];

  // control register
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ctrl_q <= periph_clk_pkg::CTRL_RESET;
    end else if (we_i && addr_i == periph_clk_pkg::CTRL_OFS) begin
      ctrl_q <= wdata_i & periph_clk_pkg::CTRL_MASK; // see R2
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (re_i) begin
      case (addr_i)
        periph_clk_pkg::CTRL_OFS: rdata_q <= ctrl_q;
        periph_clk_pkg::STAT_OFS: rdata_q <= status;
        default:                  rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  always_comb begin
    status = 8'h00;
    status[periph_clk_pkg::ST_ACT_BIT] = pck_act;
    status[periph_clk_pkg::ST_PCK_BIT] = pck_lvl;
    status[periph_clk_pkg::ST_SPI_BIT] = spi_lvl;
  end

  // free-running prescaler shared by both clock generators
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // peripheral clock source and ratio
  assign pck_act = periph_clk_enable && !sleep_i; // see R2 see R5

  always_comb begin
    case (div_sel) // see R3 see R4
      periph_clk_pkg::PCK_DIV2: pck_tick = tick_at(cnt_q, periph_clk_pkg::K_DIV2);
      periph_clk_pkg::PCK_DIV4: pck_tick = tick_at(cnt_q, periph_clk_pkg::K_DIV4);
      periph_clk_pkg::PCK_DIV8: pck_tick = tick_at(cnt_q, periph_clk_pkg::K_DIV8);
      periph_clk_pkg::PCK_TMR:  pck_tick = timer0_period_match_i;
      default:                  pck_tick = 1'b0;
    endcase
  end

  rate_toggle pck_gen (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_i),
    .clear_i  (!pck_act),
    .follow_i (1'b0),
    .src_i    (1'b0),
    .tick_i   (pck_tick),
    .level_o  (pck_lvl)
  );

  // shared pin: clock function or ordinary i/o
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pin_q    <= 1'b0;
      pin_oe_q <= 1'b0;
    end else if (periph_clk_enable) begin
      pin_q    <= pck_lvl; // see R1
      pin_oe_q <= 1'b1;
    end else begin
      pin_q    <= gpio_out_i;
      pin_oe_q <= gpio_oe_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      gpio_in_q <= 1'b0;
    end else begin
      gpio_in_q <= periph_clk_out_pin_i;
    end
  end

  // serial mode decode
  assign serial_if_enable_o = ctrl_q[periph_clk_pkg::SIF_EN_BIT];
  assign serial_mode_sel_o  = mode; // see R9
  assign spi_master_o = serial_if_enable_o && mode <= periph_clk_pkg::MODE_SPI_M_TMR; // see R6 see R7
  assign spi_slave_o  = serial_if_enable_o && mode == periph_clk_pkg::MODE_SPI_SLAVE; // see R8
  assign i2c_slave_o  = serial_if_enable_o && mode == periph_clk_pkg::MODE_I2C_SLAVE; // see R9
  assign io_mode_o    = mode == periph_clk_pkg::MODE_IO; // see R9

  // spi master clock; none in slave mode since the external master drives it
  assign spi_act    = spi_master_o; // see R8
  assign spi_follow = mode == periph_clk_pkg::MODE_SPI_M_LIRC; // see R7

  always_comb begin
    case (mode) // see R6 see R7
      periph_clk_pkg::MODE_SPI_M_DIV4:  spi_tick = tick_at(cnt_q, periph_clk_pkg::K_DIV4);
      periph_clk_pkg::MODE_SPI_M_DIV16: spi_tick = tick_at(cnt_q, periph_clk_pkg::K_DIV16);
      periph_clk_pkg::MODE_SPI_M_DIV64: spi_tick = tick_at(cnt_q, periph_clk_pkg::K_DIV64);
      periph_clk_pkg::MODE_SPI_M_TMR:   spi_tick = timer0_period_match_i;
      default:                          spi_tick = 1'b0;
    endcase
  end

  rate_toggle spi_gen (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_i),
    .clear_i  (!spi_act),
    .follow_i (spi_follow),
    .src_i    (low_speed_rc_clock_i),
    .tick_i   (spi_tick),
    .level_o  (spi_lvl)
  );

  assign rdata_o                 = rdata_q;
  assign periph_clk_out_pin_o    = pin_q;
  assign periph_clk_out_pin_oe_o = pin_oe_q;
  assign gpio_in_o               = gpio_in_q;
  assign spi_master_clk_o        = spi_lvl;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  a_pin_clock_func: assert property (periph_clk_enable |=> periph_clk_out_pin_oe_o && // see R1
      periph_clk_out_pin_o == $past(pck_lvl))
    else $error("shared pin not handed to clock output");
  a_enable_write: assert property (we_i && addr_i == periph_clk_pkg::CTRL_OFS |=> // see R2
      periph_clk_enable == $past(wdata_i[periph_clk_pkg::PCK_EN_BIT]))
    else $error("clock enable write not taken");
  a_div2_toggle: assert property ($past(pck_act && div_sel == periph_clk_pkg::PCK_DIV2) |-> // see R4
      pck_lvl != $past(pck_lvl))
    else $error("divide by two output did not toggle");
  a_div8_hold: assert property ($past(pck_act && div_sel == periph_clk_pkg::PCK_DIV8 && cnt_q[1:0] != 2'h3) |-> // see R4
      pck_lvl == $past(pck_lvl))
    else $error("divide by eight output toggled early");
  a_timer_source: assert property ($past(pck_act && div_sel == periph_clk_pkg::PCK_TMR) |-> // see R3
      (pck_lvl != $past(pck_lvl)) == $past(timer0_period_match_i))
    else $error("timer source toggle mismatch");
  a_sleep_stops: assert property (sleep_i ##1 (sleep_i && periph_clk_enable) |-> // see R5
      !pck_lvl ##1 !periph_clk_out_pin_o)
    else $error("clock output active in sleep");
  a_spi_div16: assert property ($past(spi_act && mode == periph_clk_pkg::MODE_SPI_M_DIV16) |-> // see R6
      (spi_lvl != $past(spi_lvl)) == ($past(cnt_q[2:0]) == 3'h7))
    else $error("spi divide by sixteen wrong");
  a_spi_lirc: assert property ($past(spi_act && spi_follow) |-> spi_lvl == $past(low_speed_rc_clock_i)) // see R7
    else $error("spi clock does not follow rc clock");
  a_slave_no_clk: assert property (spi_slave_o ##1 spi_slave_o |-> !spi_master_clk_o && !spi_master_o) // see R8
    else $error("spi slave drives its own clock");
  a_mode_decode: assert property (we_i && addr_i == periph_clk_pkg::CTRL_OFS && wdata_i[7:5] == 3'h6 && // see R9
      wdata_i[1] |=> i2c_slave_o && !io_mode_o)
    else $error("i2c slave mode not selected");
endmodule : periph_clk_out
`default_nettype wire

// ### verification/clock_sink.sv
// external hardware model that takes the peripheral clock off the shared pin
// assumes the pin is sampled on the system clock; an undriven pin shows changing values
`default_nettype none
module clock_sink (
  input  wire logic clock_i,
  input  wire logic pin_o_i,
  input  wire logic pin_oe_i,
  output logic      pin_level_o,
  output int        edges_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q = 1'b0;
  int   rise_q = 0;
  // undriven pin shows the inverse of its last value
  assign pin_level_o = pin_oe_i ? pin_o_i : ~last_q;
  assign edges_o     = rise_q;
  // counts rising edges of the supplied clock
  always @(posedge clock_i) begin
    last_q <= pin_level_o;
    if (pin_level_o && !last_q && pin_oe_i) begin
      rise_q <= rise_q + 1;
    end
  end
endmodule : clock_sink
`default_nettype wire

// ### verification/periph_clk_out_bench.sv
// self-checking bench for the peripheral clock output and serial mode decode
// assumes the clock_sink model and the design package are compiled first
`default_nettype none
module periph_clk_out_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i = 0, rst_b_i = 0, we_i = 0, re_i = 0, sleep_i = 0, tmr = 0, rc = 0;
  logic       g_out = 0, g_oe = 0, pin_o, pin_oe, pin_lvl, gpio_in, sif_en, spi_m, spi_s, i2c_s, io_m;
  logic       spi_clk, spi_clk_d = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, rd;
  logic [2:0] mode;
  int         failures = 0, n_compared = 0, pck_edges, spi_edges = 0, cyc = 0, pe, se;
  int         exp_s[8] = '{32, 8, 2, 8, 16, 0, 0, 0};
  always #25 clock_i = ~clock_i;
  periph_clk_out uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .timer0_period_match_i(tmr),
    .low_speed_rc_clock_i(rc), .gpio_out_i(g_out), .gpio_oe_i(g_oe), .gpio_in_o(gpio_in),
    .periph_clk_out_pin_i(pin_lvl), .periph_clk_out_pin_o(pin_o), .periph_clk_out_pin_oe_o(pin_oe),
    .serial_if_enable_o(sif_en), .serial_mode_sel_o(mode), .spi_master_o(spi_m), .spi_slave_o(spi_s),
    .i2c_slave_o(i2c_s), .io_mode_o(io_m), .spi_master_clk_o(spi_clk));
  clock_sink sink (.clock_i(clock_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_level_o(pin_lvl),
    .edges_o(pck_edges));
  // timer match every 4 cycles, rc clock period 16 cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    rc <= cyc[3];
    tmr <= (cyc % 4 == 0);
    spi_clk_d <= spi_clk;
    if (spi_clk && !spi_clk_d) begin
      spi_edges <= spi_edges + 1;
    end
    if (cyc == 4000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    we_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    we_i <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clock_i);
    re_i <= 1;
    addr_i <= a;
    @(posedge clock_i);
    re_i <= 0;
    #1 rd = rdata_o;
  endtask : rdr
  // edges of pin clock and spi clock over 128 cycles
  task automatic win();
    int p0, s0;
    // settle so that no edge of the previous setting is counted
    repeat (4) @(posedge clock_i);
    #1 p0 = pck_edges;
    s0 = spi_edges;
    repeat (128) @(posedge clock_i);
    #1 pe = pck_edges - p0;
    se = spi_edges - s0;
  endtask : win
  task automatic t_reset();
    rdr(periph_clk_pkg::CTRL_OFS);
    chk(rd, periph_clk_pkg::CTRL_RESET);
    rdr(8'h05);
    chk(rd, 8'h00);
    chk({7'h00, io_m}, 8'h01);
    $display("test reset done");
  endtask : t_reset
  task automatic t_gpio();
    @(posedge clock_i);
    g_out <= 1;
    g_oe <= 1;
    repeat (3) @(posedge clock_i);
    #1 chk({5'h00, gpio_in, pin_oe, pin_o}, 8'h07);
    $display("test gpio done");
  endtask : t_gpio
  task automatic t_div();
    for (int s = 0; s < 3; s++) begin
      wr(periph_clk_pkg::CTRL_OFS, 8'h10 | 8'(s << 2));
      win();
      chk(8'(pe), 8'(128 / (2 << s)));
      chk({7'h00, pin_oe}, 8'h01);
    end
    wr(periph_clk_pkg::CTRL_OFS, 8'h00);
    win();
    chk(8'(pe), 8'h00);
    $display("test divider done");
  endtask : t_div
  task automatic t_tmr();
    wr(periph_clk_pkg::CTRL_OFS, 8'h1D);
    win();
    chk(8'(pe), 8'h10);
    rdr(periph_clk_pkg::CTRL_OFS);
    chk(rd, 8'h1C);
    rdr(periph_clk_pkg::STAT_OFS);
    chk(rd & 8'h01, 8'h01);
    $display("test timer source done");
  endtask : t_tmr
  task automatic t_sleep();
    wr(periph_clk_pkg::CTRL_OFS, 8'h10);
    sleep_i <= 1;
    repeat (3) @(posedge clock_i);
    #1 chk({6'h00, pin_oe, pin_o}, 8'h02);
    rdr(periph_clk_pkg::STAT_OFS);
    chk(rd & 8'h03, 8'h00);
    win();
    chk(8'(pe), 8'h00);
    @(posedge clock_i);
    sleep_i <= 0;
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(periph_clk_pkg::CTRL_OFS, {m, 5'h02});
      win();
      chk({1'b0, mode, spi_m, spi_s, i2c_s, io_m}, {1'b0, m, m <= 3'h4, m == 3'h5, m == 3'h6, m == 3'h7});
      chk({7'h00, sif_en}, 8'h01);
      chk(8'(se), 8'(exp_s[i]));
    end
    wr(periph_clk_pkg::CTRL_OFS, 8'hC0);
    #1 chk({4'h0, sif_en, spi_m, i2c_s, io_m}, 8'h00);
    $display("test modes done");
  endtask : t_modes
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1;
    t_reset();
    t_gpio();
    t_div();
    t_tmr();
    t_sleep();
    t_modes();
    wrap_up();
  end
endmodule : periph_clk_out_bench
`default_nettype wire
